// ### core/dbu_pkg.sv
// Constants, state types and widths for the dual debug serial port.
// Assumes a single 100 MHz clock and an active-low asynchronous reset.
//
// How it works
// - Two independent serial ports, index 0 wireless LAN, index 1 low-energy radio.
// - Reset frame is 460800 baud, 8 data bits, no parity, 1 stop bit.
// - Framing also supports 7 data bits, odd parity and two stop bits.
// - Each port has a 4-entry by 8-bit receive FIFO and transmit FIFO.
// - Receive FIFO fill count is readable and tracks pushes and pops.
// - Sticky parity, framing and overrun flags mark faulty or lost characters.
// - An interrupt output is raised from FIFO fill and error status bits.
// - Frames use standard RS-232 style asynchronous start/stop format.
package dbu_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int BAUD_RATE = 460_800;
    localparam logic [7:0] BIT_CYC_M1 = 8'(CLK_HZ / BAUD_RATE - 1);
    localparam logic [7:0] HALF_CYC_M1 = 8'(CLK_HZ / BAUD_RATE / 2 - 1);
    localparam logic [7:0] BAUD_ZERO = 8'h00;

    // ----------------------------------------
    // Ports and FIFOs
    // ----------------------------------------
    localparam int NPORT = 2;
    localparam int PORT_WLAN = 0;
    localparam int PORT_BLE = 1;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int PTR_W = 2;
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] CNT_FULL = 3'h4;
    localparam logic [CNT_W-1:0] CNT_EMPTY = 3'h0;
    localparam logic [PTR_W-1:0] PTR_ONE = 2'h1;
    localparam logic [PTR_W-1:0] PTR_ZERO = 2'h0;

    // ----------------------------------------
    // Frame format
    // ----------------------------------------
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_7 = 4'h7;
    localparam logic [3:0] STOP_1 = 4'h1;
    localparam logic [3:0] STOP_2 = 4'h2;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_ONE = 4'h1;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

    typedef enum logic [4:0] {
        TX_IDLE = 5'h01,
        TX_START = 5'h02,
        TX_DATA = 5'h04,
        TX_PAR = 5'h08,
        TX_STOP = 5'h10
    } dbu_tx_state_t;

    typedef enum logic [4:0] {
        RX_IDLE = 5'h01,
        RX_START = 5'h02,
        RX_DATA = 5'h04,
        RX_PAR = 5'h08,
        RX_STOP = 5'h10
    } dbu_rx_state_t;

endpackage

// ### core/dbu_fifo.sv
// Four-entry by eight-bit flip-flop FIFO with valid/ready on both sides.
// Assumes the clock and reset of the serial port top.
module dbu_fifo import dbu_pkg::*; (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    input wire logic [DATA_W-1:0] wr_data_in,
    output logic rd_valid_out,
    input wire logic rd_ready_in,
    output logic [DATA_W-1:0] rd_data_out,
    output logic [CNT_W-1:0] count_out
);

    logic [DATA_W-1:0] mem_q [FIFO_DEPTH];
    logic [PTR_W-1:0] wptr_q;
    logic [PTR_W-1:0] rptr_q;
    logic [CNT_W-1:0] cnt_q;
    logic do_wr;
    logic do_rd;

    assign wr_ready_out = (cnt_q != CNT_FULL);
    assign rd_valid_out = (cnt_q != CNT_EMPTY);
    assign do_wr = wr_valid_in & wr_ready_out;
    assign do_rd = rd_ready_in & rd_valid_out;
    assign rd_data_out = mem_q[rptr_q];
    assign count_out = cnt_q;

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                mem_q[i] <= BYTE_ZERO;
            end
        end else if (do_wr) begin
            mem_q[wptr_q] <= wr_data_in;
        end
    end

    // ----------------------------------------
    // Pointers and fill count
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wptr_q <= PTR_ZERO;
            rptr_q <= PTR_ZERO;
            cnt_q <= CNT_EMPTY;
        end else begin
            if (do_wr) begin
                wptr_q <= wptr_q + PTR_ONE;
            end
            if (do_rd) begin
                rptr_q <= rptr_q + PTR_ONE;
            end
            if (do_wr && !do_rd) begin
                cnt_q <= cnt_q + 3'h1;
            end else if (do_rd && !do_wr) begin
                cnt_q <= cnt_q - 3'h1;
            end
        end
    end

endmodule

// ### core/dbu_uart_top.sv
// Dual debug serial port: port 0 serves the wireless LAN side, port 1 the low-energy radio side.
// Assumes a 100 MHz clock; serial inputs are synchronous to it.
module dbu_uart_top import dbu_pkg::*; (
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic [NPORT-1:0] RXD_IN,
    output logic [NPORT-1:0] TXD_OUT,
    input wire logic [NPORT-1:0] DATA7_IN,
    input wire logic [NPORT-1:0] PARITY_EN_IN,
    input wire logic [NPORT-1:0] STOP2_IN,
    input wire logic [NPORT*DATA_W-1:0] TX_DATA_IN,
    input wire logic [NPORT-1:0] TX_VALID_IN,
    output logic [NPORT-1:0] TX_READY_OUT,
    output logic [NPORT*DATA_W-1:0] RX_DATA_OUT,
    output logic [NPORT-1:0] RX_VALID_OUT,
    input wire logic [NPORT-1:0] RX_POP_IN,
    output logic [NPORT*CNT_W-1:0] RX_COUNT_OUT,
    output logic [NPORT-1:0] PARITY_ERR_OUT,
    output logic [NPORT-1:0] FRAME_ERR_OUT,
    output logic [NPORT-1:0] OVERRUN_ERR_OUT,
    input wire logic [NPORT-1:0] ERR_CLR_IN,
    input wire logic [NPORT-1:0] IRQ_RX_EN_IN,
    input wire logic [NPORT-1:0] IRQ_TX_EN_IN,
    input wire logic [NPORT-1:0] IRQ_ERR_EN_IN,
    output logic [NPORT-1:0] IRQ_OUT
);

    for (genvar p = 0; p < NPORT; p++) begin : g_port

        logic [3:0] nbits;
        logic [3:0] nstop;
        logic [DATA_W-1:0] txf_data;
        logic txf_valid;
        logic txf_ready;
        logic [CNT_W-1:0] txf_count;
        logic rxf_ready;
        logic [CNT_W-1:0] rxf_count;

        dbu_tx_state_t tx_state_q;
        logic [7:0] tx_baud_q;
        logic [3:0] tx_bit_q;
        logic [DATA_W-1:0] tx_shift_q;
        logic tx_par_q;
        logic tx_line_q;
        logic tx_tick;

        dbu_rx_state_t rx_state_q;
        logic [7:0] rx_baud_q;
        logic [3:0] rx_bit_q;
        logic [DATA_W-1:0] rx_shift_q;
        logic rx_par_q;
        logic rx_pbad_q;
        logic rx_push_q;
        logic rx_fbad_q;
        logic [DATA_W-1:0] rx_byte_q;
        logic rx_tick;

        logic perr_q;
        logic ferr_q;
        logic oerr_q;
        logic irq_q;

        assign nbits = DATA7_IN[p] ? BITS_7 : BITS_8;
        assign nstop = STOP2_IN[p] ? STOP_2 : STOP_1;
        assign tx_tick = (tx_baud_q == BAUD_ZERO);
        assign rx_tick = (rx_baud_q == BAUD_ZERO);
        assign txf_ready = (tx_state_q == TX_IDLE);

        // ----------------------------------------
        // FIFOs
        // ----------------------------------------
        dbu_fifo u_tx_fifo (
            .clk_in(CLK_IN),
            .arst_n_in(ARST_N_IN),
            .wr_valid_in(TX_VALID_IN[p]),
            .wr_ready_out(TX_READY_OUT[p]),
            .wr_data_in(TX_DATA_IN[p*DATA_W +: DATA_W]),
            .rd_valid_out(txf_valid),
            .rd_ready_in(txf_ready),
            .rd_data_out(txf_data),
            .count_out(txf_count)
        );

        dbu_fifo u_rx_fifo (
            .clk_in(CLK_IN),
            .arst_n_in(ARST_N_IN),
            .wr_valid_in(rx_push_q),
            .wr_ready_out(rxf_ready),
            .wr_data_in(rx_byte_q),
            .rd_valid_out(RX_VALID_OUT[p]),
            .rd_ready_in(RX_POP_IN[p]),
            .rd_data_out(RX_DATA_OUT[p*DATA_W +: DATA_W]),
            .count_out(rxf_count)
        );

        assign RX_COUNT_OUT[p*CNT_W +: CNT_W] = rxf_count;

        // ----------------------------------------
        // Transmit bit timer
        // ----------------------------------------
        always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
                tx_baud_q <= BIT_CYC_M1;
            end else if (tx_state_q == TX_IDLE || tx_tick) begin
                tx_baud_q <= BIT_CYC_M1;
            end else begin
                tx_baud_q <= tx_baud_q - 8'h01;
            end
        end

        // ----------------------------------------
        // Transmit framer
        // ----------------------------------------
        always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
                tx_state_q <= TX_IDLE;
                tx_bit_q <= BIT_ZERO;
                tx_shift_q <= BYTE_ZERO;
                tx_par_q <= 1'b1;
                tx_line_q <= 1'b1;
            end else begin
                unique case (tx_state_q)
                    TX_IDLE: begin
                        if (txf_valid) begin
                            tx_shift_q <= txf_data;
                            tx_par_q <= 1'b1;
                            tx_line_q <= 1'b0;
                            tx_state_q <= TX_START;
                        end
                    end
                    TX_START: begin
                        if (tx_tick) begin
                            tx_line_q <= tx_shift_q[0];
                            tx_par_q <= tx_par_q ^ tx_shift_q[0];
                            tx_shift_q <= {1'b0, tx_shift_q[DATA_W-1:1]};
                            tx_bit_q <= BIT_ONE;
                            tx_state_q <= TX_DATA;
                        end
                    end
                    TX_DATA: begin
                        if (tx_tick) begin
                            if (tx_bit_q == nbits) begin
                                if (PARITY_EN_IN[p]) begin
                                    tx_line_q <= tx_par_q;
                                    tx_state_q <= TX_PAR;
                                end else begin
                                    tx_line_q <= 1'b1;
                                    tx_bit_q <= BIT_ONE;
                                    tx_state_q <= TX_STOP;
                                end
                            end else begin
                                tx_line_q <= tx_shift_q[0];
                                tx_par_q <= tx_par_q ^ tx_shift_q[0];
                                tx_shift_q <= {1'b0, tx_shift_q[DATA_W-1:1]};
                                tx_bit_q <= tx_bit_q + BIT_ONE;
                            end
                        end
                    end
                    TX_PAR: begin
                        if (tx_tick) begin
                            tx_line_q <= 1'b1;
                            tx_bit_q <= BIT_ONE;
                            tx_state_q <= TX_STOP;
                        end
                    end
                    TX_STOP: begin
                        if (tx_tick) begin
                            if (tx_bit_q == nstop) begin
                                tx_state_q <= TX_IDLE;
                            end else begin
                                tx_bit_q <= tx_bit_q + BIT_ONE;
                            end
                        end
                    end
                    default: begin
                        tx_state_q <= TX_IDLE;
                        tx_line_q <= 1'b1;
                    end
                endcase
            end
        end

        assign TXD_OUT[p] = tx_line_q;

        // ----------------------------------------
        // Receive deframer
        // ----------------------------------------
        always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
                rx_state_q <= RX_IDLE;
                rx_baud_q <= HALF_CYC_M1;
                rx_bit_q <= BIT_ZERO;
                rx_shift_q <= BYTE_ZERO;
                rx_par_q <= 1'b0;
                rx_pbad_q <= 1'b0;
                rx_fbad_q <= 1'b0;
                rx_push_q <= 1'b0;
                rx_byte_q <= BYTE_ZERO;
            end else begin
                rx_push_q <= 1'b0;
                if (rx_state_q != RX_IDLE) begin
                    rx_baud_q <= rx_tick ? BIT_CYC_M1 : rx_baud_q - 8'h01;
                end
                unique case (rx_state_q)
                    RX_IDLE: begin
                        if (!RXD_IN[p]) begin
                            rx_baud_q <= HALF_CYC_M1;
                            rx_state_q <= RX_START;
                        end
                    end
                    RX_START: begin
                        if (rx_tick) begin
                            rx_bit_q <= BIT_ZERO;
                            rx_par_q <= 1'b0;
                            rx_pbad_q <= 1'b0;
                            rx_state_q <= RXD_IN[p] ? RX_IDLE : RX_DATA;
                        end
                    end
                    RX_DATA: begin
                        if (rx_tick) begin
                            rx_shift_q <= {RXD_IN[p], rx_shift_q[DATA_W-1:1]};
                            rx_par_q <= rx_par_q ^ RXD_IN[p];
                            rx_bit_q <= rx_bit_q + BIT_ONE;
                            if (rx_bit_q == nbits - BIT_ONE) begin
                                rx_state_q <= PARITY_EN_IN[p] ? RX_PAR : RX_STOP;
                            end
                        end
                    end
                    RX_PAR: begin
                        if (rx_tick) begin
                            rx_pbad_q <= ~(rx_par_q ^ RXD_IN[p]);
                            rx_state_q <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        if (rx_tick) begin
                            rx_fbad_q <= ~RXD_IN[p];
                            rx_byte_q <= DATA7_IN[p] ? {1'b0, rx_shift_q[DATA_W-1:1]} : rx_shift_q;
                            rx_push_q <= 1'b1;
                            rx_state_q <= RX_IDLE;
                        end
                    end
                    default: begin
                        rx_state_q <= RX_IDLE;
                    end
                endcase
            end
        end

        // ----------------------------------------
        // Sticky error flags
        // ----------------------------------------
        always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
                perr_q <= 1'b0;
                ferr_q <= 1'b0;
                oerr_q <= 1'b0;
            end else begin
                perr_q <= (perr_q & ~ERR_CLR_IN[p]) | (rx_push_q & rx_pbad_q);
                ferr_q <= (ferr_q & ~ERR_CLR_IN[p]) | (rx_push_q & rx_fbad_q);
                oerr_q <= (oerr_q & ~ERR_CLR_IN[p]) | (rx_push_q & ~rxf_ready);
            end
        end

        assign PARITY_ERR_OUT[p] = perr_q;
        assign FRAME_ERR_OUT[p] = ferr_q;
        assign OVERRUN_ERR_OUT[p] = oerr_q;

        // ----------------------------------------
        // Interrupt request
        // ----------------------------------------
        always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
                irq_q <= 1'b0;
            end else begin
                irq_q <= (IRQ_RX_EN_IN[p] & (rxf_count != CNT_EMPTY))
                       | (IRQ_TX_EN_IN[p] & (txf_count == CNT_EMPTY))
                       | (IRQ_ERR_EN_IN[p] & (perr_q | ferr_q | oerr_q));
            end
        end

        assign IRQ_OUT[p] = irq_q;
    end

endmodule

// ### verif/dbu_uart_asserts.sv
// Concurrent checks on the dual serial port top, port 0 in detail.
// Assumes one clock domain and an active-low asynchronous reset.
module dbu_uart_asserts import dbu_pkg::*; (
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic [NPORT-1:0] TXD_OUT,
    input wire logic [NPORT-1:0] TX_VALID_IN,
    input wire logic [NPORT-1:0] TX_READY_OUT,
    input wire logic [NPORT*DATA_W-1:0] RX_DATA_OUT,
    input wire logic [NPORT-1:0] RX_VALID_OUT,
    input wire logic [NPORT-1:0] RX_POP_IN,
    input wire logic [NPORT*CNT_W-1:0] RX_COUNT_OUT,
    input wire logic [NPORT-1:0] PARITY_ERR_OUT,
    input wire logic [NPORT-1:0] FRAME_ERR_OUT,
    input wire logic [NPORT-1:0] OVERRUN_ERR_OUT,
    input wire logic [NPORT-1:0] ERR_CLR_IN,
    input wire logic [NPORT-1:0] IRQ_RX_EN_IN,
    input wire logic [NPORT-1:0] IRQ_TX_EN_IN,
    input wire logic [NPORT-1:0] IRQ_ERR_EN_IN,
    input wire logic [NPORT-1:0] IRQ_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Helper logic
    // ----
    logic [11:0] low_run_q;
    logic [CNT_W-1:0] cnt0;
    logic [2:0] flags;
    logic cause;
    assign cnt0 = RX_COUNT_OUT[2:0];
    assign flags = {PARITY_ERR_OUT[0], FRAME_ERR_OUT[0], OVERRUN_ERR_OUT[0]};
    assign cause = (IRQ_RX_EN_IN[0] && RX_VALID_OUT[0]) || (IRQ_ERR_EN_IN[0] && (flags != 3'h0));
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            low_run_q <= 12'h000;
        end else if (TXD_OUT[0]) begin
            low_run_q <= 12'h000;
        end else begin
            low_run_q <= low_run_q + 12'h001;
        end
    end
    // ----
    // Properties
    // ----
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    sequence s_rx_held;
        RX_VALID_OUT[0] && !RX_POP_IN[0];
    endsequence
    sequence s_head_kept;
        RX_VALID_OUT[0] && $stable(RX_DATA_OUT[7:0]);
    endsequence
    a_valid_count: assert property (RX_VALID_OUT[0] == (cnt0 != CNT_EMPTY))
        else $error("valid does not match count");
    a_count_step: assert property (cnt0 == $past(cnt0) || cnt0 == $past(cnt0) + 3'h1 || cnt0 + 3'h1 == $past(cnt0))
        else $error("count jumped");
    a_count_max: assert property (cnt0 <= CNT_FULL)
        else $error("count above depth");
    a_err_sticky: assert property (!ERR_CLR_IN[0] |=> (flags & $past(flags)) == $past(flags))
        else $error("error flag lost without clear");
    a_irq_set: assert property ($past(cause) |-> IRQ_OUT[0])
        else $error("interrupt missing");
    a_irq_quiet: assert property ($past(!cause && !IRQ_TX_EN_IN[0]) |-> !IRQ_OUT[0])
        else $error("interrupt without cause");
    a_tx_bit_len: assert property ($rose(TXD_OUT[0]) |-> low_run_q != 12'h000 && low_run_q % ({4'h0, BIT_CYC_M1} + 12'h001) == 12'h000)
        else $error("low run not whole bits");
    a_ready_fall: assert property ($fell(TX_READY_OUT[0]) |-> $past(TX_VALID_IN[0]))
        else $error("ready fell without write");
    a_head_hold: assert property (s_rx_held |=> s_head_kept)
        else $error("head changed without pop");
    a_port1_valid: assert property (RX_VALID_OUT[1] == (RX_COUNT_OUT[5:3] != CNT_EMPTY))
        else $error("port 1 valid does not match count");
endmodule

bind dbu_uart_top dbu_uart_asserts u_dbu_uart_asserts (.CLK_IN, .ARST_N_IN, .TXD_OUT, .TX_VALID_IN, .TX_READY_OUT,
    .RX_DATA_OUT, .RX_VALID_OUT, .RX_POP_IN, .RX_COUNT_OUT, .PARITY_ERR_OUT, .FRAME_ERR_OUT, .OVERRUN_ERR_OUT,
    .ERR_CLR_IN, .IRQ_RX_EN_IN, .IRQ_TX_EN_IN, .IRQ_ERR_EN_IN, .IRQ_OUT);

// ### verif/dbu_term_model.sv
// Terminal model for one serial line: sends frames and decodes the device's frames.
// Assumes the bench clock and the bit period of dbu_pkg.
module dbu_term_model import dbu_pkg::*; (
    input wire logic clk_in,
    input wire logic txd_in,
    input wire logic data7_in,
    input wire logic par_en_in,
    output logic rxd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] got_q [$];
    logic [9:0] w;
    initial rxd_out = 1'b1;
    task automatic send(input logic [7:0] b, input logic m7, input logic mp, input logic m2, input logic bad_par,
                        input logic bad_stop);
        logic [11:0] f;
        int n;
        f = 12'hFFF;
        f[0] = 1'b0;
        f[8:1] = b;
        if (m7) begin
            f[8] = 1'b1;
        end
        n = m7 ? 8 : 9;
        if (mp) begin
            f[n] = ~^(m7 ? {1'b0, b[6:0]} : b) ^ bad_par;
            n++;
        end
        f[n] = ~bad_stop;
        n = n + (m2 ? 2 : 1);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            rxd_out <= f[i];
            repeat (BIT_CYC_M1) @(posedge clk_in);
        end
        @(posedge clk_in);
        rxd_out <= 1'b1;
    endtask
    initial begin
        forever begin
            @(posedge clk_in);
            if (txd_in === 1'b0) begin
                w = 10'h000;
                repeat (HALF_CYC_M1 + 8'h01) @(posedge clk_in);
                for (int i = 0; i < (data7_in ? 7 : 8); i++) begin
                    repeat (BIT_CYC_M1 + 8'h01) @(posedge clk_in);
                    w[i] = txd_in;
                end
                if (par_en_in) begin
                    repeat (BIT_CYC_M1 + 8'h01) @(posedge clk_in);
                    w[8] = txd_in;
                end
                repeat (BIT_CYC_M1 + 8'h01) @(posedge clk_in);
                w[9] = txd_in;
                got_q.push_back(w);
            end
        end
    end
endmodule

// ### verif/tb.sv
// Self-checking bench for the dual debug serial port.
// Assumes dbu_pkg and one terminal model on each port's lines.
module tb import dbu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, arst_n;
    logic [1:0] rxd, txd, d7, par, st2, tx_valid, tx_ready, rx_valid, rx_pop, perr, ferr, oerr, clr, rx_en, tx_en;
    logic [1:0] er_en, irq;
    logic [15:0] tx_data, rx_data;
    logic [5:0] rx_count;
    logic [9:0] w;
    logic [7:0] d [5];
    logic [7:0] q [$];
    int error_cnt, checked, seed;
    dbu_uart_top u_dbu_uart_top (.CLK_IN(clk), .ARST_N_IN(arst_n), .RXD_IN(rxd), .TXD_OUT(txd), .DATA7_IN(d7),
        .PARITY_EN_IN(par), .STOP2_IN(st2), .TX_DATA_IN(tx_data), .TX_VALID_IN(tx_valid), .TX_READY_OUT(tx_ready),
        .RX_DATA_OUT(rx_data), .RX_VALID_OUT(rx_valid), .RX_POP_IN(rx_pop), .RX_COUNT_OUT(rx_count),
        .PARITY_ERR_OUT(perr), .FRAME_ERR_OUT(ferr), .OVERRUN_ERR_OUT(oerr), .ERR_CLR_IN(clr),
        .IRQ_RX_EN_IN(rx_en), .IRQ_TX_EN_IN(tx_en), .IRQ_ERR_EN_IN(er_en), .IRQ_OUT(irq));
    dbu_term_model term0 (.clk_in(clk), .txd_in(txd[0]), .data7_in(d7[0]), .par_en_in(par[0]), .rxd_out(rxd[0]));
    dbu_term_model term1 (.clk_in(clk), .txd_in(txd[1]), .data7_in(d7[1]), .par_en_in(par[1]), .rxd_out(rxd[1]));
    // ----
    // Expectation and checking
    // ----
    function automatic logic [9:0] exp_word(input logic [7:0] b, input logic m7, input logic mp);
        logic [7:0] v;
        v = m7 ? {1'b0, b[6:0]} : b;
        return {1'b1, mp & ~^v, v};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic fail_wait();
        error_cnt++;
        $display("mismatch at %0t: wait ran out", $time);
        report_and_stop();
    endtask
    task automatic tx_one(input int p, input logic [7:0] b);
        int k;
        @(posedge clk);
        tx_data[p*8+:8] <= b;
        tx_valid[p] <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (!tx_ready[p] && k < 9);
        if (!tx_ready[p]) fail_wait();
        tx_valid[p] <= 1'b0;
    endtask
    task automatic check_term(input int p, input logic [9:0] e);
        int k;
        for (k = 0; k < 30000 && (p == 1 ? term1.got_q.size() : term0.got_q.size()) == 0; k++) @(posedge clk);
        if (k == 30000) fail_wait();
        if (p == 1) w = term1.got_q.pop_front();
        else w = term0.got_q.pop_front();
        check(16'(w), 16'(e));
    endtask
    // ----
    // Stimulus
    // ----
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (90000) @(posedge clk);
        fail_wait();
    end
    initial begin
        arst_n = 1'b0;
        tx_data = 16'h0000;
        {d7, par, st2, tx_valid, rx_pop, clr, rx_en, tx_en, er_en} = 18'h00000;
        seed = $urandom(1);
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        check({txd, tx_ready, rx_valid, irq}, 16'h00F0);
        check({rx_count, perr, ferr, oerr}, 16'h0000);
        $display("test reset done");
        for (int m = 0; m < 8; m++) begin
            d[0] = (m == 0) ? 8'hFF : (m == 7) ? 8'h45 : 8'($urandom);
            d[1] = 8'($urandom);
            d7 <= {2{m[0]}};
            par <= {2{m[1]}};
            st2 <= {2{m[2]}};
            fork
                term0.send(d[0], m[0], m[1], m[2], 1'b0, 1'b0);
                term1.send(d[1], m[0], m[1], m[2], 1'b0, 1'b0);
                tx_one(0, d[1]);
                tx_one(1, d[0]);
            join
            repeat (2) @(posedge clk);
            w = exp_word(d[0], m[0], m[1]);
            check(16'(rx_data[7:0]), 16'(w[7:0]));
            w = exp_word(d[1], m[0], m[1]);
            check(16'(rx_data[15:8]), 16'(w[7:0]));
            check({rx_count, perr, ferr, oerr}, 16'h0240);
            check_term(0, exp_word(d[1], m[0], m[1]));
            check_term(1, exp_word(d[0], m[0], m[1]));
            rx_pop <= 2'b11;
            @(posedge clk);
            rx_pop <= 2'b00;
            repeat (600) @(posedge clk);
            check(16'(rx_count), 16'h0000);
        end
        $display("test frame modes done");
        {d7, par, st2} <= 6'h00;
        tx_valid[0] <= 1'b1;
        for (int k = 0; k < 9; k++) begin
            @(posedge clk);
            if (!tx_ready[0]) break;
            q.push_back(tx_data[7:0]);
            tx_data[7:0] <= 8'($urandom);
        end
        @(posedge clk);
        tx_valid[0] <= 1'b0;
        tx_en[0] <= 1'b1;
        check(16'(q.size()), 16'h0005);
        repeat (2) @(posedge clk);
        check(16'(irq), 16'h0000);
        while (q.size() > 0) check_term(0, {2'b10, q.pop_front()});
        repeat (2) @(posedge clk);
        check(16'(irq), 16'h0001);
        tx_en[0] <= 1'b0;
        $display("test transmit queue done");
        par[0] <= 1'b1;
        st2[0] <= 1'b1;
        rx_en[0] <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            d[k] = 8'($urandom);
            term0.send(d[k], 1'b0, 1'b1, 1'b1, k == 1, k == 2);
            repeat (2) @(posedge clk);
            check(16'({perr[0], ferr[0], oerr[0]}), 16'({k > 0, k > 1, k > 3}));
            check(16'(rx_count), 16'((k < 4) ? k + 1 : 4));
        end
        check(16'(irq), 16'h0001);
        rx_en[0] <= 1'b0;
        er_en[0] <= 1'b1;
        repeat (2) @(posedge clk);
        check(16'(irq), 16'h0001);
        clr[0] <= 1'b1;
        @(posedge clk);
        clr[0] <= 1'b0;
        repeat (2) @(posedge clk);
        check({perr, ferr, oerr, irq}, 16'h0000);
        rx_pop[0] <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            check(16'(rx_data[7:0]), 16'(d[k]));
        end
        @(posedge clk);
        rx_pop[0] <= 1'b0;
        repeat (2) @(posedge clk);
        check(16'(rx_count), 16'h0000);
        $display("test receive errors done");
        report_and_stop();
    end
endmodule
